// ===== wcache_pkg.sv
// shared constants and types for the posted write cache and read hit logic
package wcache_pkg;

    // command codes presented by the host interface decoder
    typedef enum logic [2:0] {
        OP_READ,
        OP_WR_PIO,
        OP_WR_MULTI,
        OP_WR_DMA,
        OP_WC_ON,
        OP_WC_OFF,
        OP_OTHER
    } cmd_op_e;

    localparam int   LBA_W      = 28;
    localparam int   CNT_W      = 8;
    localparam int   DATA_W     = 16;
    localparam int   FIFO_DEPTH = 16;
    localparam int   BUF_AW     = 12;
    localparam logic WC_DEFAULT = 1'b1;

    function automatic logic is_write(input cmd_op_e op);
        return (op == OP_WR_PIO) || (op == OP_WR_MULTI) || (op == OP_WR_DMA);
    endfunction

endpackage

// ===== wcache_ctrl.sv
// sector fifo and command/media control for the posted write cache
`timescale 1ns/100ps
`default_nettype none

module sector_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)
(
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      fill_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (fill_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid_o = (fill_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop)
                fill_r <= fill_r + 1'b1;
            else if (pop && !push)
                fill_r <= fill_r - 1'b1;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

module wcache_ctrl
    import wcache_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire cmd_op_e           cmd_op_i,
    input  wire logic [LBA_W-1:0]  cmd_lba_i,
    input  wire logic [CNT_W-1:0]  cmd_cnt_i,
    input  wire logic              hard_rst_req_i,
    input  wire logic              soft_rst_req_i,
    output logic                   rst_done_o,
    output logic                   done_o,
    output logic                   done_err_o,
    output logic      [LBA_W-1:0]  err_lba_o,
    output logic                   wc_en_o,
    input  wire logic              hwr_valid_i,
    output logic                   hwr_ready_o,
    input  wire logic [DATA_W-1:0] hwr_data_i,
    output logic                   host_xfer_start_o,
    output logic      [BUF_AW-1:0] host_transfer_pointer_o,
    output logic      [CNT_W-1:0]  host_xfer_cnt_o,
    input  wire logic              host_xfer_done_i,
    output logic                   media_rd_start_o,
    output logic      [BUF_AW-1:0] media_transfer_pointer_o,
    output logic      [LBA_W-1:0]  media_rd_lba_o,
    output logic      [CNT_W-1:0]  media_rd_cnt_o,
    output logic                   med_seek_o,
    input  wire logic              med_seek_done_i,
    output logic                   med_wr_valid_o,
    input  wire logic              med_wr_ready_i,
    output logic      [LBA_W-1:0]  med_wr_lba_o,
    output logic      [DATA_W-1:0] med_wr_data_o,
    input  wire logic              med_wr_fail_i
);
    typedef enum {S_IDLE, S_RECV, S_DRAIN, S_READ} cmd_state_e;
    typedef enum {M_IDLE, M_SEEK, M_WRITE} med_state_e;

    cmd_state_e       cst_r;
    med_state_e       mst_r;
    cmd_op_e          op_r;
    logic             wc_en_r;
    logic             err_pend_r;
    logic             err_owed_r;
    logic             rst_pend_r;
    logic [CNT_W-1:0] rx_rem_r;
    logic [LBA_W-1:0] act_lba_r;
    logic [LBA_W-1:0] act_rem_r;
    logic             pend_vld_r;
    logic [LBA_W-1:0] pend_lba_r;
    logic [LBA_W-1:0] pend_cnt_r;
    logic             cache_vld_r;
    logic [LBA_W-1:0] cache_lba_r;
    logic [LBA_W-1:0] cache_cnt_r;
    logic [LBA_W-1:0] tail_end;
    logic [LBA_W-1:0] cache_end;
    logic [LBA_W-1:0] hit_cnt;
    logic             take;
    logic             take_wr;
    logic             seq_wr;
    logic             drained;
    logic             lead_hit;
    logic             fifo_in_valid;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic             fifo_pop;
    logic             wr_hs;
    logic             rx_last;

    assign take        = cmd_valid_i && cmd_ready_o;
    assign take_wr     = take && is_write(cmd_op_i);
    assign cmd_ready_o = (cst_r == S_IDLE) && !rst_pend_r && !pend_vld_r;
    assign drained     = (mst_r == M_IDLE) && !pend_vld_r;
    assign tail_end    = pend_vld_r ? pend_lba_r + pend_cnt_r : act_lba_r + act_rem_r;
    assign seq_wr      = (cmd_lba_i == tail_end);
    assign cache_end   = cache_lba_r + cache_cnt_r;
    assign lead_hit    = cache_vld_r && (cmd_lba_i >= cache_lba_r) && (cmd_lba_i < cache_end);
    assign hit_cnt     = lead_hit ? cache_end - cmd_lba_i : '0;
    assign wc_en_o     = wc_en_r;

    ////////////////////////////////////////////////////////////////////////////
    // host data into the sector buffer; fifo fullness stalls the host

    assign fifo_in_valid = hwr_valid_i && (cst_r == S_RECV);
    assign hwr_ready_o   = fifo_in_ready && (cst_r == S_RECV);
    assign rx_last       = fifo_in_valid && fifo_in_ready && (rx_rem_r == CNT_W'(1));
    assign med_wr_valid_o = (mst_r == M_WRITE) && fifo_out_valid;
    assign wr_hs         = med_wr_valid_o && med_wr_ready_i;
    assign fifo_pop      = wr_hs;
    assign med_wr_lba_o  = act_lba_r;

    sector_fifo
    #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (hwr_data_i),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (med_wr_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // command sequencing and completion

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cst_r      <= S_IDLE;
            op_r       <= OP_OTHER;
            rx_rem_r   <= '0;
            done_o     <= 1'b0;
            done_err_o <= 1'b0;
            err_owed_r <= 1'b0;
            rst_done_o <= 1'b0;
        end
        else
        begin
            done_o     <= 1'b0;
            done_err_o <= 1'b0;
            rst_done_o <= 1'b0;
            case (cst_r)
                S_IDLE:
                begin
                    // pending flag clears one edge late; no second grant pulse
                    if (rst_pend_r && drained && !rst_done_o)
                        rst_done_o <= 1'b1;
                    else if (take)
                    begin
                        op_r       <= cmd_op_i;
                        err_owed_r <= err_pend_r && is_write(cmd_op_i);
                        if (err_pend_r && !is_write(cmd_op_i))
                            done_err_o <= 1'b1;
                        else if (is_write(cmd_op_i))
                        begin
                            rx_rem_r <= cmd_cnt_i;
                            cst_r    <= S_RECV;
                        end
                        else if (cmd_op_i == OP_READ)
                            cst_r <= S_READ;
                        else
                            cst_r <= S_DRAIN;
                    end
                end
                S_RECV:
                begin
                    if (fifo_in_valid && fifo_in_ready)
                        rx_rem_r <= rx_rem_r - 1'b1;
                    if (rx_last)
                    begin
                        // owed error waits until this write is on media
                        if (!wc_en_r || err_owed_r)
                            cst_r <= S_DRAIN;
                        else
                        begin
                            // posted: media writing carries on behind this
                            done_o     <= 1'b1;
                            cst_r      <= S_IDLE;
                        end
                    end
                end
                S_DRAIN:
                begin
                    if (drained)
                    begin
                        done_o     <= !err_owed_r;
                        done_err_o <= err_owed_r;
                        err_owed_r <= 1'b0;
                        cst_r      <= S_IDLE;
                    end
                end
                S_READ:
                begin
                    if (host_xfer_done_i)
                    begin
                        done_o <= 1'b1;
                        cst_r  <= S_IDLE;
                    end
                end
                default:
                    cst_r <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error, reset and write-cache enable state

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            wc_en_r    <= WC_DEFAULT;
            err_pend_r <= 1'b0;
            err_lba_o  <= '0;
            rst_pend_r <= 1'b0;
        end
        else
        begin
            if (hard_rst_req_i || soft_rst_req_i)
                rst_pend_r <= 1'b1;
            else if (rst_done_o)
                rst_pend_r <= 1'b0;
            if (take && cmd_op_i == OP_WC_ON)
                wc_en_r <= 1'b1;
            else if (done_err_o)
                wc_en_r <= 1'b0;
            else if (cst_r == S_DRAIN && op_r == OP_WC_OFF && drained)
                wc_en_r <= 1'b0;
            // a new failure wins over the clear done by the taking command
            if (wr_hs && med_wr_fail_i)
            begin
                err_pend_r <= 1'b1;
                err_lba_o  <= act_lba_r;
            end
            else if (take || (rst_pend_r && drained && cst_r == S_IDLE))
                err_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // background media write engine; reassigned sectors arrive as success

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            mst_r      <= M_IDLE;
            act_lba_r  <= '0;
            act_rem_r  <= '0;
            pend_vld_r <= 1'b0;
            pend_lba_r <= '0;
            pend_cnt_r <= '0;
            med_seek_o <= 1'b0;
        end
        else
        begin
            med_seek_o <= 1'b0;
            if (take_wr && mst_r != M_IDLE && seq_wr)
            begin
                if (pend_vld_r)
                    pend_cnt_r <= pend_cnt_r + LBA_W'(cmd_cnt_i);
                else
                    act_rem_r <= act_rem_r - LBA_W'(wr_hs) + LBA_W'(cmd_cnt_i);
            end
            else if (take_wr && mst_r != M_IDLE)
            begin
                pend_vld_r <= 1'b1;
                pend_lba_r <= cmd_lba_i;
                pend_cnt_r <= LBA_W'(cmd_cnt_i);
            end
            else if (take_wr)
            begin
                act_lba_r  <= cmd_lba_i;
                act_rem_r  <= LBA_W'(cmd_cnt_i);
                med_seek_o <= 1'b1;
                mst_r      <= M_SEEK;
            end
            if (mst_r == M_SEEK && med_seek_done_i)
                mst_r <= M_WRITE;
            if (wr_hs)
            begin
                // a failed sector is dropped and the next one follows
                act_lba_r <= act_lba_r + 1'b1;
                if (!(take_wr && seq_wr && !pend_vld_r))
                    act_rem_r <= act_rem_r - 1'b1;
                if (act_rem_r == LBA_W'(1) && !(take_wr && seq_wr))
                begin
                    if (pend_vld_r)
                    begin
                        act_lba_r  <= pend_lba_r;
                        act_rem_r  <= pend_cnt_r;
                        pend_vld_r <= 1'b0;
                        med_seek_o <= 1'b1;
                        mst_r      <= M_SEEK;
                    end
                    else if (take_wr)
                    begin
                        // queued in this very cycle: start it at once
                        act_lba_r  <= cmd_lba_i;
                        act_rem_r  <= LBA_W'(cmd_cnt_i);
                        pend_vld_r <= 1'b0;
                        med_seek_o <= 1'b1;
                        mst_r      <= M_SEEK;
                    end
                    else
                        mst_r <= M_IDLE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read cache window and read launch

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cache_vld_r <= 1'b0;
            cache_lba_r <= '0;
            cache_cnt_r <= '0;
        end
        else if (rst_done_o)
            cache_vld_r <= 1'b0;
        else if (take_wr)
        begin
            cache_vld_r <= 1'b1;
            if (cache_vld_r && cmd_lba_i == cache_end)
                cache_cnt_r <= cache_cnt_r + LBA_W'(cmd_cnt_i);
            else
            begin
                cache_lba_r <= cmd_lba_i;
                cache_cnt_r <= LBA_W'(cmd_cnt_i);
            end
        end
        else if (take && cmd_op_i == OP_READ && hit_cnt < LBA_W'(cmd_cnt_i))
        begin
            cache_vld_r <= 1'b1;
            cache_lba_r <= cmd_lba_i;
            cache_cnt_r <= LBA_W'(cmd_cnt_i);
        end
        else if (take && cmd_op_i != OP_READ)
            cache_vld_r <= 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            host_xfer_start_o        <= 1'b0;
            media_rd_start_o         <= 1'b0;
            host_transfer_pointer_o  <= '0;
            media_transfer_pointer_o <= '0;
            host_xfer_cnt_o          <= '0;
            media_rd_lba_o           <= '0;
            media_rd_cnt_o           <= '0;
        end
        else
        begin
            host_xfer_start_o <= 1'b0;
            media_rd_start_o  <= 1'b0;
            if (take && cmd_op_i == OP_READ && !err_pend_r)
            begin
                // buffer slot is the sector address modulo buffer size
                host_transfer_pointer_o  <= cmd_lba_i[BUF_AW-1:0];
                media_transfer_pointer_o <= cmd_lba_i[BUF_AW-1:0] + hit_cnt[BUF_AW-1:0];
                media_rd_lba_o           <= cmd_lba_i + hit_cnt;
                host_xfer_cnt_o          <= cmd_cnt_i;
                host_xfer_start_o        <= 1'b1;
                if (hit_cnt < LBA_W'(cmd_cnt_i))
                begin
                    media_rd_start_o <= 1'b1;
                    media_rd_cnt_o   <= cmd_cnt_i - hit_cnt[CNT_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_lead_ptr;
        @(posedge clock_i) disable iff (sys_rst_i)
        (take && cmd_op_i == OP_READ && !err_pend_r && lead_hit)
            |=> (media_transfer_pointer_o == host_transfer_pointer_o
                 + BUF_AW'($past(hit_cnt)));
    endproperty
    a_lead_ptr: assert property (p_lead_ptr) else $error("partial hit pointers wrong");

    property p_together;
        @(posedge clock_i) disable iff (sys_rst_i)
        media_rd_start_o |-> host_xfer_start_o;
    endproperty
    a_together: assert property (p_together) else $error("media read without host xfer");

    property p_posted;
        @(posedge clock_i) disable iff (sys_rst_i)
        (rx_last && wc_en_r && !err_owed_r) |=> done_o && !done_err_o && cst_r == S_IDLE;
    endproperty
    a_posted: assert property (p_posted) else $error("posted write not completed");

    property p_owed;
        @(posedge clock_i) disable iff (sys_rst_i)
        (rx_last && err_owed_r) |=> cst_r == S_DRAIN && !done_o && !done_err_o;
    endproperty
    a_owed: assert property (p_owed) else $error("error reported before write");

    property p_no_search;
        @(posedge clock_i) disable iff (sys_rst_i)
        (take_wr && seq_wr && mst_r != M_IDLE && !pend_vld_r) |=> !med_seek_o;
    endproperty
    a_no_search: assert property (p_no_search) else $error("search on chained write");

    property p_search;
        @(posedge clock_i) disable iff (sys_rst_i)
        (take_wr && mst_r == M_IDLE) |=> med_seek_o && mst_r == M_SEEK;
    endproperty
    a_search: assert property (p_search) else $error("no search from idle");

    property p_rst_held;
        @(posedge clock_i) disable iff (sys_rst_i)
        rst_done_o |-> $past(drained) && $past(rst_pend_r);
    endproperty
    a_rst_held: assert property (p_rst_held) else $error("reset ran over dirty data");

    property p_refuse;
        @(posedge clock_i) disable iff (sys_rst_i)
        (take && err_pend_r && !is_write(cmd_op_i)) |=> done_err_o && !done_o ##1 !wc_en_r;
    endproperty
    a_refuse: assert property (p_refuse) else $error("pending error not reported");

    property p_power_on;
        @(posedge clock_i)
        $past(sys_rst_i) |-> wc_en_r;
    endproperty
    a_power_on: assert property (p_power_on) else $error("cache not on after reset");

endmodule

`default_nettype wire

// ===== media_model.sv
// media channel responder model for the write cache bench
`timescale 1ns/100ps
`default_nettype none
module media_model
    import wcache_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    input  wire logic             seek_i,
    output logic                  seek_done_o,
    input  wire logic [LBA_W-1:0] lba_i,
    output logic                  ready_o,
    output logic                  fail_o,
    input  wire logic [LBA_W-1:0] fail_lba_i,
    input  wire logic             slow_i
);
    int wait_r;
    always_ff @(posedge clock_i)
    begin
        seek_done_o <= 1'b0;
        if (sys_rst_i)
            wait_r <= 0;
        else if (seek_i)
            wait_r <= slow_i ? 40 : 4;
        else if (wait_r > 0)
        begin
            wait_r <= wait_r - 1;
            seek_done_o <= (wait_r == 1);
        end
    end
    // stalls when slow so back to back writes overlap the media
    always_ff @(posedge clock_i)
        ready_o <= !sys_rst_i && (!slow_i || ($urandom % 4 == 0));
    // retries exhausted on one chosen sector
    assign fail_o = ready_o && (lba_i == fail_lba_i);
endmodule
`default_nettype wire

// ===== disk_write_cache_and_partial_hit_test.sv
// self-checking bench for the write cache controller
`timescale 1ns/100ps
`default_nettype none
module disk_write_cache_and_partial_hit_test;
    import wcache_pkg::*;
    logic clock_i = 0, sys_rst_i = 1, cv = 0, hr = 0, sr = 0, hv = 0, hxd = 0, slow = 0;
    cmd_op_e op = OP_OTHER;
    logic [LBA_W-1:0] lba = 0, fl = '1, el, ml;
    logic [CNT_W-1:0] cnt = 1, hc, mc;
    logic [DATA_W-1:0] hd = 0, md;
    logic cr, rd_, dn, de, wc, hrd, hxs, mrs, sk, skd, mv, mr, mf, e;
    logic [BUF_AW-1:0] hp, mp, hp_s, mp_s;
    int failures = 0, total_checks = 0, cyc = 0, n_dn = 0, n_de = 0, n_sk = 0, n_rd = 0;
    int n_hx = 0, n_rst = 0, sent = 0, hs = 0;
    logic [LBA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] dat_q[$];
    logic [LBA_W-1:0] el_unused;
    wcache_ctrl uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cv), .cmd_ready_o(cr),
        .cmd_op_i(op), .cmd_lba_i(lba), .cmd_cnt_i(cnt), .hard_rst_req_i(hr), .soft_rst_req_i(sr),
        .rst_done_o(rd_), .done_o(dn), .done_err_o(de), .err_lba_o(el), .wc_en_o(wc),
        .hwr_valid_i(hv), .hwr_ready_o(hrd), .hwr_data_i(hd), .host_xfer_start_o(hxs),
        .host_transfer_pointer_o(hp), .host_xfer_cnt_o(hc), .host_xfer_done_i(hxd),
        .media_rd_start_o(mrs), .media_transfer_pointer_o(mp), .media_rd_lba_o(ml),
        .media_rd_cnt_o(mc), .med_seek_o(sk), .med_seek_done_i(skd), .med_wr_valid_o(mv),
        .med_wr_ready_i(mr), .med_wr_lba_o(el_unused), .med_wr_data_o(md), .med_wr_fail_i(mf));
    media_model mm (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .seek_i(sk), .seek_done_o(skd),
        .lba_i(el_unused), .ready_o(mr), .fail_o(mf), .fail_lba_i(fl), .slow_i(slow));
    initial
        forever #2 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [63:0] seen, input logic [63:0] want, input string what);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, want, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc++;
        n_dn += (dn === 1);
        n_de += (de === 1);
        n_sk += (sk === 1);
        n_rst += (rd_ === 1);
        if (mrs === 1)
        begin
            n_rd++;
            chk(hxs, 1, "media read with host start");
        end
        if (hxs === 1)
        begin
            n_hx++;
            hp_s = hp;
            mp_s = mp;
        end
        if (mv === 1 && mr === 1)
        begin
            chk(el_unused, exp_q.pop_front(), "media lba");
            chk(md, dat_q.pop_front(), "media data");
            hs++;
        end
        if (rd_ === 1)
            chk(hs, sent, "drained at reset");
        if (cyc == 40000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task cmd(input cmd_op_e o, input logic [LBA_W-1:0] a, input logic [CNT_W-1:0] c);
        int t;
        op <= o;
        lba <= a;
        cnt <= c;
        cv <= 1;
        t = 0;
        do @(posedge clock_i); while (cr !== 1 && ++t < 3000);
        cv <= 0;
    endtask
    // w data words follow the command; e reports an abnormal end
    task wr(input cmd_op_e o, input logic [LBA_W-1:0] a, input int c, input int w, output logic e);
        int t, d0, e0;
        logic [DATA_W-1:0] x;
        d0 = n_dn + n_de;
        e0 = n_de;
        cmd(o, a, CNT_W'(c));
        for (int k = 0; k < w; k++)
        begin
            x = DATA_W'($urandom);
            hd <= x;
            hv <= 1;
            exp_q.push_back(a + LBA_W'(k));
            dat_q.push_back(x);
            t = 0;
            do @(posedge clock_i); while (hrd !== 1 && ++t < 3000);
            sent++;
        end
        hv <= 0;
        t = 0;
        while (n_dn + n_de == d0 && ++t < 3000) @(posedge clock_i);
        // one more edge so state changed with the end pulse has settled
        @(posedge clock_i);
        e = (n_de != e0);
    endtask
    task rd(input logic [LBA_W-1:0] a, input int c, input int media, input int buffered);
        int t, h0, r0, d0;
        h0 = n_hx;
        r0 = n_rd;
        d0 = n_dn;
        cmd(OP_READ, a, CNT_W'(c));
        t = 0;
        while (n_hx == h0 && ++t < 100) @(posedge clock_i);
        chk(n_rd - r0, media, "media read issued");
        chk(hp_s, a[BUF_AW-1:0], "host pointer");
        if (media == 1 && buffered > 0)
            chk(mp_s, BUF_AW'(a + LBA_W'(buffered)), "media pointer");
        chk(hc, CNT_W'(c), "host count");
        if (media == 1)
        begin
            chk(ml, a + LBA_W'(buffered), "media read lba");
            chk(mc, CNT_W'(c - buffered), "media read count");
        end
        hxd <= 1;
        @(posedge clock_i);
        hxd <= 0;
        t = 0;
        while (n_dn == d0 && ++t < 100) @(posedge clock_i);
        chk(n_dn - d0, 1, "read done");
    endtask
    task drain;
        int t;
        t = 0;
        while (hs != sent && ++t < 8000) @(posedge clock_i);
        repeat (3) @(posedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n0, r0;
        void'($urandom(46310));
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 0;
        @(posedge clock_i);
        chk(wc, 1, "cache on at power-on");
        slow <= 1;
        n0 = n_sk;
        wr(OP_WR_PIO, 'h40, 4, 4, e);
        chk(hs < sent, 1, "posted before media");
        wr(OP_WR_MULTI, 'h44, 2, 2, e);
        chk(n_sk - n0, 1, "no search when chained");
        drain();
        wr(OP_WR_DMA, 'h46, 1, 1, e);
        chk(n_sk - n0, 2, "search after idle");
        wr(OP_WR_PIO, 'h80, 3, 3, e);
        wr(OP_WR_PIO, 'h10, 2, 2, e);
        drain();
        // only the latest written extent stays cached, here 'h10..'h11
        rd('h10, 2, 0, 2);
        rd('h10, 5, 1, 2);
        wr(OP_OTHER, 0, 1, 0, e);
        rd('h10, 1, 1, 0);
        // random writes with no media fault end normally
        for (int i = 0; i < 6; i++)
        begin
            slow <= 1'($urandom);
            n0 = 1 + $urandom % 4;
            wr(cmd_op_e'(1 + $urandom % 3), 'h400 + LBA_W'($urandom % 'h100), n0, n0, e);
            chk(e, 0, "normal end");
        end
        slow <= 1;
        for (int i = 0; i < 2; i++)
        begin
            wr(OP_WR_PIO, 'h500, 3, 3, e);
            r0 = n_rst;
            hr <= (i == 0);
            sr <= (i == 1);
            @(posedge clock_i);
            hr <= 0;
            sr <= 0;
            n0 = 0;
            while (n_rst == r0 && ++n0 < 8000) @(posedge clock_i);
            // a doubled grant pulse would be counted here
            repeat (3) @(posedge clock_i);
            chk(n_rst - r0, 1, "reset granted");
        end
        wr(OP_WR_DMA, 'h520, 2, 2, e);
        wr(OP_WC_OFF, 0, 1, 0, e);
        chk(hs, sent, "drained before disable");
        chk(wc, 0, "cache off");
        wr(OP_WC_ON, 0, 1, 0, e);
        slow <= 0;
        fl <= 'h601;
        wr(OP_WR_PIO, 'h600, 3, 3, e);
        drain();
        chk(el, 'h601, "failed sector");
        wr(OP_OTHER, 0, 1, 0, e);
        chk(e, 1, "abnormal end");
        chk(wc, 0, "cache off after fault");
        wr(OP_WC_ON, 0, 1, 0, e);
        chk(wc, 1, "cache back on");
        fl <= 'h701;
        wr(OP_WR_DMA, 'h700, 2, 2, e);
        drain();
        wr(OP_WR_PIO, 'h720, 1, 1, e);
        chk(e, 1, "error after write");
        chk(hs, sent, "write done first");
        tally_and_finish;
    end
endmodule
`default_nettype wire
